// ==== bench/sfs_far_model.sv ====
// converter and calibration memory model for the supervisor bench
// assumes conv_start and nvm_read_req are one-cycle pulses on aclk
`timescale 1ns/10ps
module sfs_far_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // converter side, mode 0 prompt, 1 never done, 2 out of range
    input wire logic [1:0] conv_mode,
    input wire logic conv_start,
    output logic conv_done,
    output logic conv_out_of_range,
    // memory side
    input wire logic nvm_fail,
    input wire logic nvm_read_req,
    output logic nvm_fault
);
    logic busy_q;
    logic [3:0] cnt_q;
    // done stays high several cycles so the pin synchroniser sees the edge
    assign conv_done = busy_q && (cnt_q < 4'h6);
    // ----------------------------------------------------------------
    // conversion timing and memory fault answer
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            nvm_fault <= 1'b0;
            conv_out_of_range <= 1'b0;
        end else begin
            nvm_fault <= nvm_read_req && nvm_fail;
            // idle range line toggles, it is not held by anyone
            conv_out_of_range <= busy_q ? (conv_mode == 2'h2) : ~conv_out_of_range;
            if (conv_start && conv_mode != 2'h1) begin
                busy_q <= 1'b1;
                cnt_q <= 4'hc;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 4'h1;
                busy_q <= (cnt_q != 4'h0);
            end
        end
    end
endmodule

// ==== bench/sfs_supervisor_tb.sv ====
// self-checking bench for the sleep and fault supervisor
// assumes shortened ticks: 4 cycles per ms, 2 ms per minute
`timescale 1ns/10ps
module sfs_supervisor_tb;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, conv_done, conv_oor, conv_start, nvm_fault;
    logic [1:0] bresp, rresp, conv_mode = 2'h0;
    logic sleep_key = 0, wake_key = 0, battery_low = 0, motion = 0, kbd = 0, invalid = 0, overload = 0;
    logic nvm_fail = 0, nvm_rd, nvm_wr, recalc, blink, inoperable, low_power;
    logic [2:0] disp_sel;
    logic [3:0] err_code;
    int n_mismatch = 0, samples_checked = 0, cycles = 0, n_rd = 0, n_wr = 0, n_calc = 0;
    logic [31:0] d, r;
    int v;
    always #25 aclk = ~aclk;
    sfs_supervisor #(.MIN_TICK_MS(2), .MS_CYC(4)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sleep_key(sleep_key), .wake_key(wake_key), .battery_low(battery_low),
        .motion(motion), .keyboard_entry(kbd), .invalid_entry(invalid), .overload(overload),
        .conv_done(conv_done), .conv_out_of_range(conv_oor), .conv_start(conv_start),
        .nvm_fault(nvm_fault), .nvm_read_req(nvm_rd), .nvm_write_req(nvm_wr), .recalc_req(recalc),
        .disp_sel(disp_sel), .err_code(err_code), .blink(blink), .inoperable(inoperable),
        .low_power(low_power));
    sfs_far_model far (.aclk(aclk), .aresetn(aresetn), .conv_mode(conv_mode), .conv_start(conv_start),
        .conv_done(conv_done), .conv_out_of_range(conv_oor), .nvm_fail(nvm_fail),
        .nvm_read_req(nvm_rd), .nvm_fault(nvm_fault));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // pulse counters and a reserved-code watch on every cycle
    always @(posedge aclk) begin
        cycles++;
        n_rd += nvm_rd;
        n_wr += nvm_wr;
        n_calc += recalc;
        if (aresetn && err_code inside {4'h4, 4'h5, 4'h6}) chk("err_code reserved", err_code, 0);
        if (cycles > 40000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // ready is combinational and stable from negedge to the next rising edge
    task automatic axw(input logic [7:0] a, input logic [31:0] wd);
        @(posedge aclk);
        awaddr <= a; wdata <= wd; awvalid <= 1; wvalid <= 1; bready <= 1;
        do @(negedge aclk); while (!(awready && wready));
        @(posedge aclk);
        awvalid <= 0; wvalid <= 0;
        do @(negedge aclk); while (!bvalid);
        @(posedge aclk);
        bready <= 0;
        chk("bresp", bresp, (a == sfs_pkg::REG_CTRL || a == sfs_pkg::REG_AUTOSLEEP) ?
            sfs_pkg::RESP_OKAY : sfs_pkg::RESP_SLVERR);
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 0;
        do @(negedge aclk); while (!rvalid);
        @(posedge aclk);
        rd = rdata; rs = rresp; rready <= 0;
    endtask
    task automatic slp();
        sleep_key <= 1; cyc(6); sleep_key <= 0; cyc(8);
    endtask
    task automatic wak();
        wake_key <= 1; cyc(6); wake_key <= 0; cyc(8);
    endtask
    function automatic logic [31:0] dsp(input logic [31:0] sel);
        return sel;
    endfunction
    initial begin
        logic [1:0] rs;
        v = $urandom(32'h2bfb4a1e);
        cyc(3); aresetn <= 1; cyc(2);
        axr(sfs_pkg::REG_AUTOSLEEP, r, rs); chk("autosleep reset", r, 0);
        axr(8'h14, r, rs); chk("unmapped resp", {rs, r[29:0]}, {sfs_pkg::RESP_SLVERR, 30'h0});
        overload <= 1; cyc(8); chk("overload disp", disp_sel, dsp(sfs_pkg::DISP_OVERLOAD));
        chk("inoperable", inoperable, 1);
        slp(); chk("sleep over ovl", disp_sel, dsp(sfs_pkg::DISP_SLEEP));
        chk("low_power", low_power, 1);
        d = n_rd; overload <= 0; wak(); chk("awake", {disp_sel, low_power, inoperable}, 0);
        chk("reload", n_rd, d + 1);
        axw(sfs_pkg::REG_AUTOSLEEP, 0); motion <= 0; cyc(60); chk("never", low_power, 0);
        // idle minutes piled up under setting zero, so motion clears them before the new setting lands
        v = 1 + $urandom_range(2); motion <= 1; cyc(6); axw(sfs_pkg::REG_AUTOSLEEP, v);
        cyc(8 * v + 20); chk("motion holds", low_power, 0);
        axw(sfs_pkg::REG_CTRL, 1); motion <= 0; cyc(8 * v + 20); chk("setup holds", low_power, 0);
        axw(sfs_pkg::REG_CTRL, 0); kbd <= 1; cyc(8 * v + 20); chk("kbd holds", low_power, 0);
        kbd <= 0; cyc(8 * v - 6); chk("not yet", low_power, 0);
        cyc(30); chk("auto sleep", low_power, 1);
        axw(sfs_pkg::REG_AUTOSLEEP, 0); wak();
        kbd <= 1; battery_low <= 1; cyc(10); chk("no dead kbd", low_power, 0);
        kbd <= 0; cyc(10); chk("dead", disp_sel, dsp(sfs_pkg::DISP_BATTERY_DEAD));
        wak(); chk("dead again", disp_sel, dsp(sfs_pkg::DISP_BATTERY_DEAD));
        battery_low <= 0; wak(); chk("restart", low_power, 0);
        axw(sfs_pkg::REG_CTRL, 4); cyc(2); chk("cal err", {disp_sel, err_code}, {3'h3, sfs_pkg::ERR_CAL});
        slp(); nvm_fail <= 1; wak(); chk("nvm err", err_code, sfs_pkg::ERR_NVM);
        nvm_fail <= 0; slp(); wak(); chk("read retry", err_code, sfs_pkg::ERR_NONE);
        axw(sfs_pkg::REG_CTRL, 2); cyc(2); chk("stale", err_code, sfs_pkg::ERR_NOT_CALC);
        d = n_calc; r = n_wr; axw(sfs_pkg::REG_CTRL, 1); axw(sfs_pkg::REG_CTRL, 0); cyc(2);
        chk("recalc", n_calc, d + 1);
        chk("stale cleared", err_code, sfs_pkg::ERR_NONE);
        chk("write retry", n_wr, r + 1);
        conv_mode <= 1; axw(sfs_pkg::REG_CTRL, 8); cyc(260); chk("conv wait", err_code, 0);
        cyc(30); chk("conv timeout", err_code, sfs_pkg::ERR_CONV_TIMEOUT);
        conv_mode <= 2; axw(sfs_pkg::REG_CTRL, 8); cyc(30); chk("range", err_code, sfs_pkg::ERR_RANGE);
        conv_mode <= 0; axw(sfs_pkg::REG_CTRL, 8); cyc(30); chk("conv ok", err_code, 0);
        invalid <= 1; cyc(20); invalid <= 0; chk("blink on", blink, 1);
        cyc(7900); chk("blink held", blink, 1);
        cyc(120); chk("blink off", blink, 0);
        end_sim();
    end
endmodule

// ==== common/sfs_pkg.sv ====
// sleep and fault supervisor: shared constants, register map, display codes
// assumes a 20 MHz system clock and AXI4-Lite register access
package sfs_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MS_TICK_CYC = CLK_HZ / MS_PER_S;
    localparam int unsigned MS_PER_MIN = 60000;
    localparam int unsigned BLINK_MS = 2000;
    localparam int unsigned CONV_TIMEOUT_MS = 70;
    localparam int unsigned SYNC_LEN = 3;

    // ----------------------------------------------------------------
    // register map, byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_AUTOSLEEP = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_DISPLAY = 8'h0c;
    localparam logic [7:0] REG_MINUTES = 8'h10;

    // ctrl fields, write-one pulses except setup
    localparam int unsigned CTRL_SETUP_BIT = 0;
    localparam int unsigned CTRL_PARAM_CHG_BIT = 1;
    localparam int unsigned CTRL_CAL_BAD_BIT = 2;
    localparam int unsigned CTRL_CONV_START_BIT = 3;
    localparam logic [7:0] AUTOSLEEP_RST = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ----------------------------------------------------------------
    // display selection and error numbers
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        DISP_WEIGHT,
        DISP_SLEEP,
        DISP_BATTERY_DEAD,
        DISP_ERROR,
        DISP_OVERLOAD
    } sfs_disp_e;

    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_RANGE = 4'h1;
    localparam logic [3:0] ERR_CAL = 4'h2;
    localparam logic [3:0] ERR_NVM = 4'h3;
    localparam logic [3:0] ERR_CONV_TIMEOUT = 4'h7;
    localparam logic [3:0] ERR_NOT_CALC = 4'h8;
endpackage

// ==== rtl/sfs_supervisor.sv ====
// sleep and fault supervisor for a battery weighing indicator
// assumes keypad, battery and converter pins are asynchronous to aclk
// Operation
// - invalid entry blinks the main display for two seconds
// - a shown condition message marks the instrument inoperable until cleared
// - load above rated capacity shows the overload message instead of weight
// - sleep key enters sleep at once
// - auto-sleep setting zero never sleeps on its own
// - nonzero setting sleeps after that many motionless whole minutes
// - motion clears and holds cleared the minute counter
// - no auto-sleep during keyboard entry or setup
// - wake key leaves sleep and resumes operation
// - battery low enters sleep-like state showing the dead-battery message
// - wake key restarts from dead battery; re-enters if still low
// - no dead-battery entry during keyboard entry or setup
// - converter out-of-range during conversion shows error 1
// - calibration check failure shows error 2; wake reloads calibration
// - memory fault shows error 3; wake retries read, setup exit retries write
// - conversion not done within 70 ms is abandoned with error 7
// - stale derived values show error 8; setup exit recalculates
// - error codes 4, 5 and 6 are never produced
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module sfs_supervisor #(
    parameter int unsigned MIN_TICK_MS = sfs_pkg::MS_PER_MIN,
    parameter int unsigned MS_CYC = sfs_pkg::MS_TICK_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // keypad and sensor pins
    input wire logic sleep_key,
    input wire logic wake_key,
    input wire logic battery_low,
    input wire logic motion,
    input wire logic keyboard_entry,
    input wire logic invalid_entry,
    input wire logic overload,
    // converter
    input wire logic conv_done,
    input wire logic conv_out_of_range,
    output logic conv_start,
    // calibration memory
    input wire logic nvm_fault,
    output logic nvm_read_req,
    output logic nvm_write_req,
    output logic recalc_req,
    // display
    output logic [2:0] disp_sel,
    output logic [3:0] err_code,
    output logic blink,
    output logic inoperable,
    output logic low_power
);
    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_DEAD} sfs_state_e;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    localparam int NPIN = 9;
    logic [NPIN-1:0] pins_raw, pins_s;
    assign pins_raw = {sleep_key, wake_key, battery_low, motion, keyboard_entry,
                       invalid_entry, overload, conv_done, conv_out_of_range};
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
        sfs_sync u_sync (
            .aclk(aclk),
            .aresetn(aresetn),
            .pin(pins_raw[i]),
            .level(pins_s[i])
        );
    end
    wire sleep_s = pins_s[8];
    wire wake_s = pins_s[7];
    wire batt_s = pins_s[6];
    wire motion_s = pins_s[5];
    wire kbd_s = pins_s[4];
    wire inval_s = pins_s[3];
    wire ovl_s = pins_s[2];
    wire done_s = pins_s[1];
    wire range_s = pins_s[0];

    logic [NPIN-1:0] pins_prev_q;
    wire sleep_rise = sleep_s & ~pins_prev_q[8];
    wire wake_rise = wake_s & ~pins_prev_q[7];
    wire inval_rise = inval_s & ~pins_prev_q[3];
    wire done_rise = done_s & ~pins_prev_q[1];

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic setup_q, param_stale_q, cal_bad_q;
    logic [7:0] autosleep_q;
    logic [15:0] ms_div_q;
    logic [15:0] ms_in_min_q;
    logic [7:0] minutes_q;
    logic [10:0] blink_ms_q;
    logic [6:0] conv_ms_q;
    logic conv_busy_q, conv_start_q;
    logic err_range_q, err_nvm_q, err_timeout_q;
    logic nvm_rd_q, nvm_wr_q, recalc_q;
    sfs_state_e state_q, state_d;

    // ----------------------------------------------------------------
    // bus slave: one write and one read at a time
    // ----------------------------------------------------------------
    logic bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
    wire rd_go = s_axi_arvalid & ~rvalid_q;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    wire wr_ctrl = wr_go & (s_axi_awaddr == sfs_pkg::REG_CTRL) & s_axi_wstrb[0];
    wire wr_auto = wr_go & (s_axi_awaddr == sfs_pkg::REG_AUTOSLEEP) & s_axi_wstrb[0];
    wire wr_hit = (s_axi_awaddr == sfs_pkg::REG_CTRL) | (s_axi_awaddr == sfs_pkg::REG_AUTOSLEEP);
    wire setup_d = wr_ctrl ? s_axi_wdata[sfs_pkg::CTRL_SETUP_BIT] : setup_q;
    wire setup_exit = setup_q & ~setup_d;
    wire sw_param_chg = wr_ctrl & s_axi_wdata[sfs_pkg::CTRL_PARAM_CHG_BIT];
    wire sw_cal_bad = wr_ctrl & s_axi_wdata[sfs_pkg::CTRL_CAL_BAD_BIT];
    wire sw_conv = wr_ctrl & s_axi_wdata[sfs_pkg::CTRL_CONV_START_BIT];

    // read mux, unmapped answers slverr with zero data
    logic [31:0] rd_val;
    logic rd_hit;
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            sfs_pkg::REG_CTRL: rd_val = {29'h0, cal_bad_q, param_stale_q, setup_q};
            sfs_pkg::REG_AUTOSLEEP: rd_val = {24'h0, autosleep_q};
            sfs_pkg::REG_STATUS: rd_val = {25'h0, conv_busy_q, err_timeout_q, err_nvm_q,
                                           err_range_q, low_power, state_q};
            sfs_pkg::REG_DISPLAY: rd_val = {24'h0, blink, disp_sel, err_code};
            sfs_pkg::REG_MINUTES: rd_val = {24'h0, minutes_q};
            default: rd_hit = 1'b0;
        endcase
    end

    // response channels hold until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= sfs_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= sfs_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else begin
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? sfs_pkg::RESP_OKAY : sfs_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (rd_go) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_val;
                rresp_q <= rd_hit ? sfs_pkg::RESP_OKAY : sfs_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // time base
    // ----------------------------------------------------------------
    wire ms_tick = (ms_div_q == 16'(MS_CYC - 1));
    wire min_tick = ms_tick & (ms_in_min_q == 16'(MIN_TICK_MS - 1));
    wire auto_hold = motion_s | kbd_s | setup_q | (state_q != ST_RUN);
    wire auto_sleep = (autosleep_q != 8'h00) & (minutes_q >= autosleep_q) & ~kbd_s & ~setup_q;
    wire dead_ok = batt_s & ~kbd_s & ~setup_q;

    // minute base restarts with motion so only whole idle minutes count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ms_div_q <= 16'h0000;
            ms_in_min_q <= 16'h0000;
            minutes_q <= 8'h00;
        end else begin
            ms_div_q <= ms_tick ? 16'h0000 : ms_div_q + 16'h0001;
            if (auto_hold) begin
                ms_in_min_q <= 16'h0000;
                minutes_q <= 8'h00;
            end else if (min_tick) begin
                ms_in_min_q <= 16'h0000;
                if (minutes_q != 8'hff) minutes_q <= minutes_q + 8'h01;
            end else if (ms_tick) begin
                ms_in_min_q <= ms_in_min_q + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // power state machine
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (dead_ok) state_d = ST_DEAD;
                else if (sleep_rise | auto_sleep) state_d = ST_SLEEP;
            end
            ST_SLEEP: if (wake_rise) state_d = ST_RUN;
            ST_DEAD: if (wake_rise) state_d = ST_RUN;
        endcase
    end
    wire waking = (state_q != ST_RUN) & (state_d == ST_RUN);

    // ----------------------------------------------------------------
    // state, configuration and memory requests
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_RUN;
            pins_prev_q <= '0;
            setup_q <= 1'b0;
            autosleep_q <= sfs_pkg::AUTOSLEEP_RST;
            nvm_rd_q <= 1'b0;
            nvm_wr_q <= 1'b0;
            recalc_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pins_prev_q <= pins_s;
            setup_q <= setup_d;
            if (wr_auto) autosleep_q <= s_axi_wdata[7:0];
            nvm_rd_q <= waking;
            nvm_wr_q <= setup_exit;
            recalc_q <= setup_exit;
        end
    end
    assign nvm_read_req = nvm_rd_q;
    assign nvm_write_req = nvm_wr_q;
    assign recalc_req = recalc_q;
    assign low_power = (state_q != ST_RUN);

    // ----------------------------------------------------------------
    // fault flags: set, from a ctrl write or the memory fault pin, wins over clear
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            param_stale_q <= 1'b0;
            cal_bad_q <= 1'b0;
            err_nvm_q <= 1'b0;
        end else begin
            if (sw_param_chg) param_stale_q <= 1'b1;
            else if (setup_exit) param_stale_q <= 1'b0;
            if (sw_cal_bad) cal_bad_q <= 1'b1;
            else if (waking) cal_bad_q <= 1'b0;
            if (nvm_fault) err_nvm_q <= 1'b1;
            else if (waking | setup_exit) err_nvm_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // conversion watchdog
    // ----------------------------------------------------------------
    wire conv_expire = conv_busy_q & ms_tick & (conv_ms_q == 7'(sfs_pkg::CONV_TIMEOUT_MS - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_busy_q <= 1'b0;
            conv_start_q <= 1'b0;
            conv_ms_q <= 7'h00;
            err_range_q <= 1'b0;
            err_timeout_q <= 1'b0;
        end else begin
            conv_start_q <= sw_conv & ~conv_busy_q;
            if (sw_conv & ~conv_busy_q) begin
                conv_busy_q <= 1'b1;
                conv_ms_q <= 7'h00;
            end else if (conv_busy_q & done_rise) begin
                conv_busy_q <= 1'b0;
                err_range_q <= range_s;
                err_timeout_q <= 1'b0;
            end else if (conv_expire) begin
                conv_busy_q <= 1'b0;
                err_timeout_q <= 1'b1;
            end else if (conv_busy_q & ms_tick) begin
                conv_ms_q <= conv_ms_q + 7'h01;
            end
        end
    end
    assign conv_start = conv_start_q;

    // ----------------------------------------------------------------
    // blink timer
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_ms_q <= 11'h000;
        end else if (inval_rise) begin
            blink_ms_q <= 11'(sfs_pkg::BLINK_MS);
        end else if (ms_tick && blink_ms_q != 11'h000) begin
            blink_ms_q <= blink_ms_q - 11'h001;
        end
    end
    assign blink = (blink_ms_q != 11'h000);

    // ----------------------------------------------------------------
    // display priority, codes 4 to 6 never chosen
    // ----------------------------------------------------------------
    wire [3:0] err_sel = err_range_q ? sfs_pkg::ERR_RANGE :
                         cal_bad_q ? sfs_pkg::ERR_CAL :
                         err_nvm_q ? sfs_pkg::ERR_NVM :
                         err_timeout_q ? sfs_pkg::ERR_CONV_TIMEOUT :
                         param_stale_q ? sfs_pkg::ERR_NOT_CALC : sfs_pkg::ERR_NONE;
    assign err_code = err_sel;
    assign disp_sel = (state_q == ST_DEAD) ? sfs_pkg::DISP_BATTERY_DEAD :
                      (state_q == ST_SLEEP) ? sfs_pkg::DISP_SLEEP :
                      (err_sel != sfs_pkg::ERR_NONE) ? sfs_pkg::DISP_ERROR :
                      ovl_s ? sfs_pkg::DISP_OVERLOAD : sfs_pkg::DISP_WEIGHT;
    assign inoperable = (disp_sel != sfs_pkg::DISP_WEIGHT);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_sleep_key_entry: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == ST_RUN && sleep_rise && !dead_ok) |=> state_q == ST_SLEEP)
        else $error("sleep key ignored");
    a_zero_never_auto: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == ST_RUN && autosleep_q == 8'h00 && !sleep_rise && !dead_ok) |=> state_q == ST_RUN)
        else $error("auto sleep with zero setting");
    a_motion_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        motion_s |=> minutes_q == 8'h00)
        else $error("minute count not cleared by motion");
    a_wake_resumes: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q != ST_RUN && wake_rise) |=> (state_q == ST_RUN && nvm_read_req))
        else $error("wake did not resume");
    a_dead_entry: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == ST_RUN && dead_ok) |=> (state_q == ST_DEAD && disp_sel == sfs_pkg::DISP_BATTERY_DEAD))
        else $error("dead battery not entered");
    a_no_dead_setup: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == ST_RUN && (kbd_s || setup_q) && !sleep_rise) |=> state_q == ST_RUN)
        else $error("left run during entry or setup");
    a_timeout_code: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_expire |=> (err_timeout_q && !conv_busy_q))
        else $error("conversion timeout missed");
    a_no_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
        !(err_code inside {4'h4, 4'h5, 4'h6}))
        else $error("reserved error code shown");
    a_blink_length: assert property (@(posedge aclk) disable iff (!aresetn)
        inval_rise |=> blink_ms_q == 11'(sfs_pkg::BLINK_MS))
        else $error("blink not loaded");
    a_setup_recalc: assert property (@(posedge aclk) disable iff (!aresetn)
        (setup_exit && !sw_param_chg) |=> (recalc_req && nvm_write_req && !param_stale_q))
        else $error("setup exit did not recalc");
    c_auto_sleep: cover property (@(posedge aclk) disable iff (!aresetn)
        state_q == ST_RUN && auto_sleep);
    c_dead_wake: cover property (@(posedge aclk) disable iff (!aresetn)
        state_q == ST_DEAD && wake_rise);
    c_timeout: cover property (@(posedge aclk) disable iff (!aresetn) conv_expire);
    c_overload: cover property (@(posedge aclk) disable iff (!aresetn)
        disp_sel == sfs_pkg::DISP_OVERLOAD);
endmodule

// ==== rtl/sfs_sync.sv ====
// three-stage synchroniser with agreement filter for one pin input
// assumes the pin is asynchronous to aclk
`timescale 1ns/10ps
module sfs_sync (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pin and clean level
    input wire logic pin,
    output logic level
);
    logic [sfs_pkg::SYNC_LEN-1:0] sr_q;
    logic level_q;

    // --------------------------------------------------------------
    // shift chain, stage 0 only feeds stage 1
    // --------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sr_q <= '0;
            level_q <= 1'b0;
        end else begin
            sr_q <= {sr_q[sfs_pkg::SYNC_LEN-2:0], pin};
            if (sr_q[1] == sr_q[2]) begin
                level_q <= sr_q[1]; // change counts once stages 1 and 2 agree
            end
        end
    end
    assign level = level_q;
endmodule
